// [design/io_port.sv]
// General purpose eight-pin I/O port with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "io_port_map.svh"

module io_port #(
    parameter int PINS = 8,
    parameter int EV_CHANNELS = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [7:0] pad_in,
    output io_port_pkg::pad_ctrl_t pad_ctrl,
    // Peripheral overrides, clocks and events
    input wire io_port_pkg::periph_ovr_t periph_ovr,
    input wire logic periph_clk_level,
    input wire logic rtc_clk_level,
    input wire logic [EV_CHANNELS-1:0] event_chan,
    // Sensed pin values and remap selection to peripherals
    output logic [7:0] pin_value,
    output logic [7:0] remap_sel,
    // Port interrupts, events and wake
    output logic [1:0] port_irq,
    output logic [7:0] pin_event,
    output logic async_wake
);
    import io_port_pkg::*;

    if (PINS < 1 || PINS > 8) begin
        $error("PINS must be 1 to 8");
    end
    if (EV_CHANNELS < 1 || EV_CHANNELS > 8) begin
        $error("EV_CHANNELS must be 1 to 8");
    end

    localparam logic [7:0] PIN_MASK = 8'(({8'h00, 8'hFF} >> (8 - PINS)) & 16'h00FF);

    logic [7:0] dir;
    logic [7:0] out_val;
    logic [7:0] int_mask0;
    logic [7:0] int_mask1;
    logic [7:0] int_flags;
    logic [10:0] cfg_word [8];
    logic [3:0] clkout_ctrl;
    logic [3:0] evout_ctrl;
    logic clk_enabled;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sensed_d;
    logic [7:0] keep_level;

    // Bus slave: write address and data are held until both are present
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a <= `CLKEN_OFS) && (a[1:0] == 2'b00) &&
            !(a > `MULTICFG_OFS && a < `PINCFG_OFS) &&
            !(a > (`PINCFG_OFS + 8'h1C) && a < `CLKOUT_OFS);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr(aw_addr) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_lo;
    assign wr_lo = do_write && w_strb[0];

    function automatic logic [7:0] apply_rmw(input logic [7:0] cur, input logic [7:0] ofs,
                                             input logic [7:0] base, input logic [7:0] d);
        if (ofs == base) apply_rmw = d;
        else if (ofs == base + 8'h04) apply_rmw = cur | d;
        else if (ofs == base + 8'h08) apply_rmw = cur & ~d;
        else if (ofs == base + 8'h0C) apply_rmw = cur ^ d;
        else apply_rmw = cur;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir <= 8'h00;
        end else if (wr_lo) begin
            dir <= apply_rmw(dir, aw_addr, `DIR_OFS, w_data[7:0]) & PIN_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_val <= 8'h00;
        end else if (wr_lo) begin
            out_val <= apply_rmw(out_val, aw_addr, `OUT_OFS, w_data[7:0]) & PIN_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_mask0 <= 8'h00;
            int_mask1 <= 8'h00;
            clkout_ctrl <= 4'h0;
            evout_ctrl <= 4'h0;
            remap_sel <= 8'h00;
            clk_enabled <= 1'b1;
        end else if (wr_lo) begin
            if (aw_addr == `INTMASK0_OFS) int_mask0 <= w_data[7:0] & PIN_MASK;
            if (aw_addr == `INTMASK1_OFS) int_mask1 <= w_data[7:0] & PIN_MASK;
            if (aw_addr == `CLKOUT_OFS) clkout_ctrl <= w_data[3:0];
            if (aw_addr == `EVOUT_OFS) evout_ctrl <= w_data[3:0];
            if (aw_addr == `REMAP_OFS) remap_sel <= w_data[7:0];
            if (aw_addr == `CLKEN_OFS) clk_enabled <= w_data[0];
        end
    end

    // Per-pin configuration, single write or multi-pin write
    logic [7:0] multi_sel;
    assign multi_sel = w_data[`MULTI_SEL_LSB +: 8];

    for (genvar p = 0; p < 8; p++) begin : g_cfg
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_word[p] <= `PINCFG_RST;
            end else if (do_write && (w_strb[1:0] == 2'b11)) begin
                if (aw_addr == `PINCFG_OFS + 8'(p * 4)) begin
                    cfg_word[p] <= w_data[10:0];
                end else if (aw_addr == `MULTICFG_OFS && multi_sel[p]) begin
                    cfg_word[p] <= w_data[10:0];
                end
            end
        end
    end

    function automatic pin_cfg_t cfg_of(input logic [10:0] w);
        pin_cfg_t c;
        c.sense = sense_t'(w[`CFG_SENSE_LSB +: 3]);
        c.drive = drive_t'({1'b0, w[`CFG_DRIVE_LSB +: 2]});
        c.invert = w[`CFG_INVEN_BIT];
        c.slew_limit = w[`CFG_SLEW_BIT];
        c.pull = pull_t'(w[`CFG_PULL_LSB +: 2]);
        cfg_of = c;
    endfunction

    // Input path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= pad_in;
            sync2 <= sync1;
        end
    end

    logic [7:0] sensed;
    logic [7:0] hit;
    logic [7:0] async_hit;
    logic [7:0] drv_level;
    logic [7:0] oe_int;

    for (genvar p = 0; p < 8; p++) begin : g_pin
        pin_cfg_t c;
        logic src_out;
        logic src_oe;
        logic lvl;
        assign c = cfg_of(cfg_word[p]);
        assign sensed[p] = sync2[p] ^ c.invert;
        always_comb begin
            case (c.sense)
                SENSE_BOTH: hit[p] = sensed[p] ^ sensed_d[p];
                SENSE_RISE: hit[p] = sensed[p] & ~sensed_d[p];
                SENSE_FALL: hit[p] = ~sensed[p] & sensed_d[p];
                SENSE_LOW: hit[p] = ~sensed[p];
                default: hit[p] = 1'b0;
            endcase
        end
        // Any-change detector for wake, fed only from the synchroniser
        assign async_hit[p] = PIN_MASK[p] && (c.sense != SENSE_OFF) &&
            (sensed[p] != sensed_d[p]);

        // Output source: peripheral override, then clock/event, then port value
        always_comb begin
            src_out = out_val[p];
            src_oe = dir[p];
            if (clkout_ctrl[3] && clkout_ctrl[2:0] == 3'(p)) begin
                src_out = clkout_ctrl[0] ? rtc_clk_level : periph_clk_level;
                src_oe = 1'b1;
            end
            if (evout_ctrl[3] && p == 7) begin
                src_out = event_chan[3'(evout_ctrl[2:0]) % EV_CHANNELS];
                src_oe = 1'b1;
            end
            if (periph_ovr.ovr_en[p]) begin
                src_out = periph_ovr.ovr_out[p];
                src_oe = periph_ovr.ovr_oe[p];
            end
            lvl = src_out ^ c.invert;
            case (c.drive)
                DRV_WIRED_OR: oe_int[p] = src_oe & lvl;
                DRV_WIRED_AND: oe_int[p] = src_oe & ~lvl;
                default: oe_int[p] = src_oe;
            endcase
            drv_level[p] = lvl;
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                keep_level[p] <= 1'b0;
            end else begin
                keep_level[p] <= oe_int[p] ? drv_level[p] : sync2[p];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pad_ctrl.pad_out[p] <= 1'b0;
                pad_ctrl.pad_oe[p] <= 1'b0;
                pad_ctrl.slew_limit[p] <= 1'b0;
                pad_ctrl.pull_up_en[p] <= 1'b0;
                pad_ctrl.pull_down_en[p] <= 1'b0;
            end else begin
                pad_ctrl.pad_out[p] <= drv_level[p];
                pad_ctrl.pad_oe[p] <= oe_int[p] & PIN_MASK[p];
                pad_ctrl.slew_limit[p] <= c.slew_limit;
                if (c.drive == DRV_BUSKEEP && !oe_int[p]) begin
                    pad_ctrl.pull_up_en[p] <= keep_level[p];
                    pad_ctrl.pull_down_en[p] <= ~keep_level[p];
                end else begin
                    pad_ctrl.pull_up_en[p] <= (c.pull == PULL_UP) && !(oe_int[p] &&
                        c.drive == DRV_TOTEM);
                    pad_ctrl.pull_down_en[p] <= (c.pull == PULL_DOWN) && !(oe_int[p] &&
                        c.drive == DRV_TOTEM);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sensed_d <= 8'h00;
            pin_value <= 8'h00;
            pin_event <= 8'h00;
            async_wake <= 1'b0;
        end else begin
            sensed_d <= sensed;
            pin_value <= sensed & PIN_MASK;
            pin_event <= clk_enabled ? (hit & PIN_MASK) : 8'h00;
            async_wake <= !clk_enabled && (|async_hit);
        end
    end

    // Flags: set wins over write-one clear
    logic [7:0] flag_clr;
    logic [7:0] flag_set;
    assign flag_clr = (wr_lo && aw_addr == `INTFLAGS_OFS) ? w_data[7:0] : 8'h00;
    assign flag_set = clk_enabled ? (hit & PIN_MASK) : (async_hit & PIN_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_flags <= 8'h00;
        end else begin
            int_flags <= (int_flags & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_irq <= 2'b00;
        end else begin
            port_irq <= {|(int_flags & int_mask1), |(int_flags & int_mask0)};
        end
    end

    // Read channel
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `DIR_OFS, `DIRSET_OFS, `DIRCLR_OFS, `DIRTGL_OFS: rd_mux = {24'h000000, dir};
            `OUT_OFS, `OUTSET_OFS, `OUTCLR_OFS, `OUTTGL_OFS: rd_mux = {24'h000000, out_val};
            `IN_OFS: rd_mux = {24'h000000, sensed_d & PIN_MASK};
            `INTMASK0_OFS: rd_mux = {24'h000000, int_mask0};
            `INTMASK1_OFS: rd_mux = {24'h000000, int_mask1};
            `INTFLAGS_OFS: rd_mux = {24'h000000, int_flags};
            `CLKOUT_OFS: rd_mux = {28'h0000000, clkout_ctrl};
            `EVOUT_OFS: rd_mux = {28'h0000000, evout_ctrl};
            `REMAP_OFS: rd_mux = {24'h000000, remap_sel};
            `CLKEN_OFS: rd_mux = {31'h00000000, clk_enabled};
            default: begin
                if (s_axi_araddr >= `PINCFG_OFS && s_axi_araddr < `CLKOUT_OFS) begin
                    rd_mux = {21'h000000, cfg_word[s_axi_araddr[4:2]]};
                end
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [common/io_port_map.svh]
// Register offsets, field positions and reset values of the I/O port
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH

`define DIR_OFS        8'h00
`define DIRSET_OFS     8'h04
`define DIRCLR_OFS     8'h08
`define DIRTGL_OFS     8'h0C
`define OUT_OFS        8'h10
`define OUTSET_OFS     8'h14
`define OUTCLR_OFS     8'h18
`define OUTTGL_OFS     8'h1C
`define IN_OFS         8'h20
`define INTMASK0_OFS   8'h24
`define INTMASK1_OFS   8'h28
`define INTFLAGS_OFS   8'h2C
`define MULTICFG_OFS   8'h30
`define PINCFG_OFS     8'h40
`define CLKOUT_OFS     8'h60
`define EVOUT_OFS      8'h64
`define REMAP_OFS      8'h68
`define CLKEN_OFS      8'h6C

`define CFG_SENSE_LSB  0
`define CFG_DRIVE_LSB  3
`define CFG_INVEN_BIT  6
`define CFG_SLEW_BIT   7
`define CFG_PULL_LSB   8
`define MULTI_SEL_LSB  16

`define PINCFG_RST     11'h000
`define SYNC_STAGES    2

`endif

// [common/io_port_pkg.sv]
// Types shared by the I/O port design
package io_port_pkg;
    typedef enum logic [2:0] {
        SENSE_BOTH,
        SENSE_RISE,
        SENSE_FALL,
        SENSE_OFF,
        SENSE_LOW
    } sense_t;

    typedef enum logic [2:0] {
        DRV_TOTEM,
        DRV_BUSKEEP,
        DRV_WIRED_OR,
        DRV_WIRED_AND
    } drive_t;

    typedef enum logic [1:0] {
        PULL_NONE,
        PULL_DOWN,
        PULL_UP
    } pull_t;

    typedef struct packed {
        pull_t pull;
        logic slew_limit;
        logic invert;
        drive_t drive;
        sense_t sense;
    } pin_cfg_t;

    typedef struct packed {
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [7:0] pull_up_en;
        logic [7:0] pull_down_en;
        logic [7:0] slew_limit;
    } pad_ctrl_t;

    typedef struct packed {
        logic [7:0] ovr_en;
        logic [7:0] ovr_oe;
        logic [7:0] ovr_out;
    } periph_ovr_t;
endpackage

// [dv/io_port_props.sv]
// Port checker for the I/O port
`timescale 1ns/1ps
`default_nettype none
module io_port_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and interrupts
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pin_value,
    input wire logic [1:0] port_irq,
    input wire logic [7:0] pin_event,
    input wire logic async_wake
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] up;
    logic [5:0] wh;
    // Settling count after reset and recent write history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up <= 3'h0;
            wh <= 6'h00;
        end else begin
            if (up != 3'h7) up <= up + 3'h1;
            wh <= {wh[4:0], s_axi_wvalid & s_axi_wready};
        end
    end
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
        else $error("bad read response");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while answering");
    a_pin_quiet: assert property ((up == 3'h7 && !(s_axi_wvalid && s_axi_wready) && $stable(pad_in)) [*5] |-> $stable(pin_value))
        else $error("pin value moved with quiet pins");
    a_wake_excl: assert property (!(async_wake && |pin_event))
        else $error("wake and event together");
    a_irq_fall: assert property ($fell(port_irq[0]) || $fell(port_irq[1]) |-> |wh)
        else $error("interrupt fell without a write");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_irq: cover property (port_irq == 2'h3);
    c_wake: cover property (async_wake);
    c_event: cover property (|pin_event);
endmodule
bind io_port io_port_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pad_in(pad_in), .pin_value(pin_value), .port_irq(port_irq),
    .pin_event(pin_event), .async_wake(async_wake));
`default_nettype wire

// [dv/pin_model.sv]
// Model of the pins and board around the I/O port
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    // Clock
    input wire logic aclk,
    // Pad side of the port
    input wire io_port_pkg::pad_ctrl_t pad_ctrl,
    output logic [7:0] pad_in,
    // Board drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en
);
    import io_port_pkg::*;
    logic [7:0] last = 8'h00;
    always_ff @(posedge aclk) begin
        last <= pad_in;
    end
    // Port drive wins, then board, then pulls; a floating pin wanders
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_ctrl.pad_oe[i]) begin
                pad_in[i] = pad_ctrl.pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_ctrl.pull_up_en[i]) begin
                pad_in[i] = 1'b1;
            end else if (pad_ctrl.pull_down_en[i]) begin
                pad_in[i] = 1'b0;
            end else begin
                pad_in[i] = ~last[i];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/eight_pin_io_port_tb_top.sv]
// Self-checking bench for the I/O port
`timescale 1ns/1ps
`default_nettype none
`include "io_port_map.svh"
module eight_pin_io_port_tb_top;
    import io_port_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wake, pclk = 1'b0, rclk = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pad_in, pin_value, remap, pev;
    logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_d, seed = 32'hC071AC5B;
    logic [1:0] bresp, rresp, rd_r, irq, wr_b;
    logic [3:0] ev = 4'h0;
    pad_ctrl_t pc;
    periph_ovr_t po = '0;
    int failures = 0, samples_checked = 0;
    logic [7:0] offs [8] = '{`DIR_OFS, `DIRSET_OFS, `DIRCLR_OFS, `DIRTGL_OFS,
        `OUT_OFS, `OUTSET_OFS, `OUTCLR_OFS, `OUTTGL_OFS};
    always #20 aclk = ~aclk;
    io_port u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
        .pad_ctrl(pc), .periph_ovr(po), .periph_clk_level(pclk), .rtc_clk_level(rclk),
        .event_chan(ev), .pin_value(pin_value), .remap_sel(remap), .port_irq(irq),
        .pin_event(pev), .async_wake(wake));
    pin_model u_pins (.aclk(aclk), .pad_ctrl(pc), .pad_in(pad_in), .ext_val(ext_val),
        .ext_en(ext_en));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ta = awready | da;
            tw = wready | dw;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = ta;
            dw = tw;
        end
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            tw = bvalid;
            wr_b = bresp;
            @(posedge aclk);
        end while (!tw);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            t = rvalid;
            rd_d = rdata;
            rd_r = rresp;
            @(posedge aclk);
        end while (!t);
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_d, exp);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        report_and_stop();
    end
    initial begin
        logic [7:0] m, dm, om, sel;
        logic [31:0] r;
        logic e;
        dm = 8'h00;
        om = 8'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`DIR_OFS, 32'h0);
        rchk(`CLKEN_OFS, 32'h1);
        rd(8'hFC);
        chk(rd_r, 2'h2);
        wr(8'h34, 32'h0);
        chk(wr_b, 2'h2);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            m = i[2] ? om : dm;
            case (i[1:0])
                2'h0: m = r[7:0];
                2'h1: m = m | r[7:0];
                2'h2: m = m & ~r[7:0];
                default: m = m ^ r[7:0];
            endcase
            if (i[2]) om = m;
            else dm = m;
            wr(offs[i[2:0]], r);
            chk(wr_b, 2'h0);
            rchk(`DIR_OFS, dm);
            rchk(`OUT_OFS, om);
            chk(pc.pad_oe, dm);
            chk(pc.pad_out, om);
        end
        wr(`DIR_OFS, 32'h0);
        r = rnd();
        sel = r[7:0];
        wr(`MULTICFG_OFS, {8'h00, sel, 16'h0200});
        for (int i = 0; i < 8; i++) begin
            rchk(`PINCFG_OFS + 8'(4 * i), sel[i] ? 32'h200 : 32'h0);
        end
        chk(pc.pull_up_en, sel);
        wr(`MULTICFG_OFS, 32'h00FF0003);
        @(posedge aclk);
        ext_en <= 8'hFF;
        wr(`PINCFG_OFS + 8'h08, 32'h1);
        wr(`INTMASK0_OFS, 32'h04);
        wr(`INTMASK1_OFS, 32'h00);
        wr(`INTFLAGS_OFS, 32'hFF);
        @(posedge aclk);
        ext_val <= 8'h04;
        for (int k = 0; k < 8 && pev[2] !== 1'b1; k++) @(negedge aclk);
        chk(pev[2], 1'b1);
        cyc(3);
        rchk(`INTFLAGS_OFS, 32'h04);
        chk(irq, 2'h1);
        wr(`INTFLAGS_OFS, 32'h04);
        @(posedge aclk);
        ext_val <= 8'h00;
        cyc(6);
        rchk(`INTFLAGS_OFS, 32'h0);
        chk(irq, 2'h0);
        wr(`INTMASK1_OFS, 32'h04);
        @(posedge aclk);
        ext_val <= 8'h04;
        cyc(6);
        chk(irq, 2'h3);
        wr(`PINCFG_OFS + 8'h0C, 32'h43);
        cyc(4);
        chk(pin_value, 8'h0C);
        @(posedge aclk);
        ext_val <= 8'h0C;
        cyc(4);
        chk(pin_value, 8'h04);
        wr(`DIR_OFS, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(`PINCFG_OFS, k[1] ? 32'h1B : 32'h13);
            wr(`OUT_OFS, k[0]);
            cyc(2);
            e = k[1] ? !k[0] : k[0];
            chk(pc.pad_oe[0], e);
            if (e) chk(pc.pad_out[0], k[0]);
        end
        wr(`CLKOUT_OFS, 32'h0A);
        wr(`EVOUT_OFS, 32'h09);
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr(`REMAP_OFS, r[15:8]);
            @(posedge aclk);
            pclk <= r[0];
            rclk <= r[6];
            ev <= r[4:1];
            po <= '{ovr_en: 8'h10, ovr_oe: 8'h10, ovr_out: {3'h0, r[5], 4'h0}};
            cyc(2);
            chk({pc.pad_out[7], pc.pad_out[4], pc.pad_out[2]}, {r[2], r[5], r[0]});
            chk(remap, r[15:8]);
        end
        wr(`CLKOUT_OFS, 32'h0);
        wr(`CLKEN_OFS, 32'h0);
        @(posedge aclk);
        ext_val <= 8'h08;
        for (int k = 0; k < 8 && wake !== 1'b1; k++) @(negedge aclk);
        chk(wake, 1'b1);
        wr(`CLKEN_OFS, 32'h1);
        cyc(4);
        wr(`PINCFG_OFS + 8'h14, 32'h184);
        cyc(2);
        chk({pc.slew_limit[5], pc.pull_down_en[5], pev[5]}, 3'h7);
        wr(`PINCFG_OFS + 8'h14, 32'h0A);
        @(posedge aclk);
        ext_val <= 8'h28;
        cyc(5);
        chk({pc.pull_up_en[5], pc.pull_down_en[5]}, 2'h2);
        @(posedge aclk);
        ext_val <= 8'h08;
        for (int k = 0; k < 8 && pev[5] !== 1'b1; k++) @(negedge aclk);
        chk(pev[5], 1'b1);
        cyc(3);
        chk({pc.pull_up_en[5], pc.pull_down_en[5]}, 2'h1);
        @(posedge aclk);
        ext_en <= 8'hDF;
        cyc(4);
        chk(pin_value[5], 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
